// [ccs_pkg.sv]
// Shared constants, types and helpers for the clocked serial channel setup block
package ccs_pkg;

   // Register byte offsets on the AXI4-Lite slave
   localparam int unsigned ADDR_W = 6;
   localparam logic [5:0] OFS_MODE = 6'h00;
   localparam logic [5:0] OFS_DATA = 6'h04;
   localparam logic [5:0] OFS_LEVELS = 6'h08;
   localparam logic [5:0] OFS_ENABLES = 6'h0C;
   localparam logic [5:0] OFS_P3_LATCH = 6'h10;
   localparam logic [5:0] OFS_P3_DIR = 6'h14;
   localparam logic [5:0] OFS_P5_LATCH = 6'h18;
   localparam logic [5:0] OFS_P5_DIR = 6'h1C;
   localparam logic [5:0] OFS_START = 6'h20;
   localparam logic [5:0] OFS_STATUS = 6'h24;
   localparam logic [5:0] OFS_RXDATA = 6'h28;

   // Field positions
   localparam int unsigned LEN_LSB = 0;
   localparam int unsigned ORDER_BIT = 7;
   localparam int unsigned DIV_LSB = 9;
   localparam int unsigned CKO_BIT = 8;
   localparam int unsigned DOL_BIT = 0;
   localparam int unsigned SOE_BIT = 0;
   localparam int unsigned START_BIT = 0;
   localparam int unsigned RXV_BIT = 0;
   localparam int unsigned BADLEN_BIT = 1;
   localparam int unsigned ACTIVE_BIT = 6;
   localparam int unsigned CLK_PIN_BIT = 0;
   localparam int unsigned IN_PIN_BIT = 0;
   localparam int unsigned OUT_PIN_BIT = 1;

   // Writable bit masks
   localparam logic [15:0] MODE_MASK = 16'h0083;
   localparam logic [15:0] LEVELS_MASK = 16'h0101;
   localparam logic [15:0] ENABLES_MASK = 16'h0001;

   // Frame length codes
   localparam logic [1:0] LEN_9 = 2'h0;
   localparam logic [1:0] LEN_7 = 2'h2;
   localparam logic [1:0] LEN_8 = 2'h3;

   // Reset values
   localparam logic [15:0] RST_MODE = 16'h0003;
   localparam logic [15:0] RST_DATA = 16'h0000;
   localparam logic [15:0] RST_LEVELS = 16'h0101;
   localparam logic [15:0] RST_ENABLES = 16'h0000;
   localparam logic [7:0] RST_LATCH = 8'hFF;
   localparam logic [7:0] RST_DIR = 8'hFF;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One bit per serial pin
   typedef struct packed {
      logic clk;
      logic dout;
      logic din;
   } ccs_pins_s;

   // Settings frozen at the start of a frame
   typedef struct packed {
      logic lsb_first;
      logic [6:0] div;
      logic [3:0] bits;
      logic [8:0] tx;
   } ccs_frame_cfg_s;

   // Bits per frame for a length code, zero when not allowed in clocked mode
   function automatic logic [3:0] ccs_frame_bits(input logic [1:0] len);
      logic [3:0] r;
      r = 4'h0;
      case (len)
         LEN_8: r = 4'h8;
         LEN_7: r = 4'h7;
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   // True for every offset that holds a register
   function automatic logic ccs_mapped(input logic [5:0] a);
      logic r;
      r = 1'b0;
      case ({a[5:2], 2'h0})
         OFS_MODE, OFS_DATA, OFS_LEVELS, OFS_ENABLES, OFS_P3_LATCH, OFS_P3_DIR,
         OFS_P5_LATCH, OFS_P5_DIR, OFS_START, OFS_STATUS, OFS_RXDATA: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

endpackage

// [ccs_rx_buffer.sv]
// Small valid/ready buffer for received frames
`timescale 1ns/10ps
`default_nettype none
module ccs_rx_buffer import ccs_pkg::*; #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Below two entries a stall would cost a word
   initial begin
      if (DEPTH < 2 || WIDTH < 1) begin
         $error("ccs_rx_buffer: DEPTH must be at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [PW:0] count, next_count;
   logic push, pop;

   assign in_ready = (count < (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer wrap at any depth, not only powers of two
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         next_count = (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (PW+1)'(count - 1'b1);
      end
   end

   // Storage and pointers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule
`default_nettype wire

// [ccs_channel.sv]
// Clocked serial channel: register file, frame engine and pin routing
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Length code 11 gives 8-bit frames, 10 gives 7-bit; others refused.
// - Code 00 (9-bit) is asynchronous only, so a clocked start refuses it.
// - Divider N in data bits 15..9; serial clock is aclk over 2(N+1).
// - Clock level bit 8 sets the idle serial clock pin value.
// - Data level bit 0 sets the data output pin value.
// - With output enable set the frame engine drives data out, else not.
// - Port writes set driven level; reads in input mode return the pin.
// - Direction bit 0 turns the output buffer on, 1 turns it off.
// - Bit order 0 shifts MSB first, 1 shifts LSB first.
// - Transfer-active flag reads 1 during a frame, 0 when stopped.
module ccs_channel import ccs_pkg::*; #(
   parameter int unsigned RX_DEPTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ccs_pins_s pin_in,
   output ccs_pins_s pin_out,
   output ccs_pins_s pin_oe_n
);
   initial begin
      if (RX_DEPTH < 2) begin
         $error("ccs_channel: RX_DEPTH must be at least 2");
      end
   end

   typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_SAMPLE} ccs_state_e;

   // Byte-lane merge of a write into a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] strb, input logic [15:0] mask);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = d[7:0];
      end
      if (strb[1]) begin
         r[15:8] = d[15:8];
      end
      return r & mask;
   endfunction

   // AXI state
   logic aw_hold, w_hold, next_aw_hold, next_w_hold;
   logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
   logic [31:0] wdata_q, next_wdata_q;
   logic [3:0] wstrb_q, next_wstrb_q;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata, read_word;
   logic do_write, start_req, rx_pop;
   logic [5:0] waddr;

   // Register state
   logic [15:0] mode, data, levels, enables;
   logic [15:0] next_mode, next_data, next_levels, next_enables;
   logic [7:0] p3_latch, p3_dir, p5_latch, p5_dir;
   logic [7:0] next_p3_latch, next_p3_dir, next_p5_latch, next_p5_dir;
   logic badlen, next_badlen;

   // Engine state
   ccs_state_e state, next_state;
   ccs_frame_cfg_s cfg, next_cfg;
   logic [6:0] phase, next_phase;
   logic [3:0] idx, next_idx, cnt, next_cnt, start_bits;
   logic [8:0] rx_word, next_rx_word;
   logic push, next_push, active;

   // Pin state
   ccs_pins_s sync1, sync2, sync3, pin_f, next_pin_f;
   ccs_pins_s next_pin_out, next_pin_oe_n;
   logic serial_clk, serial_dout;

   // Received frames
   logic buf_in_ready, buf_out_valid;
   logic [8:0] buf_out_data;

   assign waddr = {awaddr_q[5:2], 2'h0};
   assign do_write = aw_hold && w_hold && !s_axi_bvalid;
   assign start_req = do_write && (waddr == OFS_START) && wdata_q[START_BIT];
   assign rx_pop = s_axi_arvalid && s_axi_arready &&
                   ({s_axi_araddr[5:2], 2'h0} == OFS_RXDATA);
   assign active = (state != ST_IDLE);
   assign start_bits = ccs_frame_bits(mode[LEN_LSB +: 2]);

   // Write and read channels; address and data may come in either order
   always_comb begin
      next_aw_hold = aw_hold;
      next_w_hold = w_hold;
      next_awaddr_q = awaddr_q;
      next_wdata_q = wdata_q;
      next_wstrb_q = wstrb_q;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_arready = s_axi_arready;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_hold = 1'b1;
         next_awaddr_q = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_hold = 1'b1;
         next_wdata_q = s_axi_wdata;
         next_wstrb_q = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_hold = 1'b0;
         next_w_hold = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = ccs_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rdata = read_word;
         next_rresp = ccs_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
      // One write at a time: stop taking until the response is gone
      next_awready = !next_aw_hold && !next_bvalid;
      next_wready = !next_w_hold && !next_bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         awaddr_q <= next_awaddr_q;
         wdata_q <= next_wdata_q;
         wstrb_q <= next_wstrb_q;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= (s_axi_arready || s_axi_rvalid) ? next_arready : 1'b1;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // Read multiplexer; port bits in input mode show the filtered pin
   always_comb begin
      read_word = 32'h0000_0000;
      case ({s_axi_araddr[5:2], 2'h0})
         OFS_MODE: read_word[15:0] = mode;
         OFS_DATA: read_word[15:0] = data;
         OFS_LEVELS: read_word[15:0] = levels;
         OFS_ENABLES: read_word[15:0] = enables;
         OFS_P3_LATCH: begin
            read_word[7:0] = p3_latch;
            read_word[CLK_PIN_BIT] = p3_dir[CLK_PIN_BIT] ? pin_f.clk : p3_latch[CLK_PIN_BIT];
         end
         OFS_P3_DIR: read_word[7:0] = p3_dir;
         OFS_P5_LATCH: begin
            read_word[7:0] = p5_latch;
            read_word[IN_PIN_BIT] = p5_dir[IN_PIN_BIT] ? pin_f.din : p5_latch[IN_PIN_BIT];
            read_word[OUT_PIN_BIT] = p5_dir[OUT_PIN_BIT] ? pin_f.dout : p5_latch[OUT_PIN_BIT];
         end
         OFS_P5_DIR: read_word[7:0] = p5_dir;
         OFS_STATUS: begin
            read_word[ACTIVE_BIT] = active;
            read_word[BADLEN_BIT] = badlen;
            read_word[RXV_BIT] = buf_out_valid;
         end
         OFS_RXDATA: read_word[8:0] = buf_out_valid ? buf_out_data : 9'h000;
         default: read_word = 32'h0000_0000;
      endcase
   end

   // Register writes; channel settings are frozen while a frame runs
   always_comb begin
      next_mode = mode;
      next_data = data;
      next_levels = levels;
      next_enables = enables;
      next_p3_latch = p3_latch;
      next_p3_dir = p3_dir;
      next_p5_latch = p5_latch;
      next_p5_dir = p5_dir;
      next_badlen = badlen;
      if (do_write) begin
         case (waddr)
            OFS_MODE: if (!active) next_mode = merge(mode, wdata_q, wstrb_q, MODE_MASK);
            OFS_DATA: if (!active) next_data = merge(data, wdata_q, wstrb_q, 16'hFFFF);
            OFS_LEVELS: if (!active) next_levels = merge(levels, wdata_q, wstrb_q, LEVELS_MASK);
            OFS_ENABLES: if (!active) next_enables = merge(enables, wdata_q, wstrb_q, ENABLES_MASK);
            OFS_P3_LATCH: if (wstrb_q[0]) next_p3_latch = wdata_q[7:0];
            OFS_P3_DIR: if (wstrb_q[0]) next_p3_dir = wdata_q[7:0];
            OFS_P5_LATCH: if (wstrb_q[0]) next_p5_latch = wdata_q[7:0];
            OFS_P5_DIR: if (wstrb_q[0]) next_p5_dir = wdata_q[7:0];
            OFS_STATUS: if (wdata_q[BADLEN_BIT]) next_badlen = 1'b0;
            default: next_badlen = next_badlen;
         endcase
      end
      // Refused start sets the flag, winning over a clear
      if (start_req && !active && start_bits == 4'h0) begin
         next_badlen = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode <= RST_MODE;
         data <= RST_DATA;
         levels <= RST_LEVELS;
         enables <= RST_ENABLES;
         p3_latch <= RST_LATCH;
         p3_dir <= RST_DIR;
         p5_latch <= RST_LATCH;
         p5_dir <= RST_DIR;
         badlen <= 1'b0;
      end else begin
         mode <= next_mode;
         data <= next_data;
         levels <= next_levels;
         enables <= next_enables;
         p3_latch <= next_p3_latch;
         p3_dir <= next_p3_dir;
         p5_latch <= next_p5_latch;
         p5_dir <= next_p5_dir;
         badlen <= next_badlen;
      end
   end

   // Frame engine; each half period lasts N+1 cycles
   always_comb begin
      next_state = state;
      next_cfg = cfg;
      next_phase = phase;
      next_idx = idx;
      next_cnt = cnt;
      next_rx_word = rx_word;
      next_push = 1'b0;
      case (state)
         ST_IDLE: begin
            // A start with no buffer room is dropped, so no word is lost
            if (start_req && start_bits != 4'h0 && buf_in_ready) begin
               next_cfg.lsb_first = mode[ORDER_BIT];
               next_cfg.div = data[DIV_LSB +: 7];
               next_cfg.bits = start_bits;
               next_cfg.tx = data[8:0];
               next_phase = 7'h00;
               next_cnt = 4'(start_bits - 4'h1);
               next_idx = mode[ORDER_BIT] ? 4'h0 : 4'(start_bits - 4'h1);
               next_rx_word = 9'h000;
               next_state = ST_DRIVE;
            end
         end
         ST_DRIVE: begin
            if (phase == cfg.div) begin
               next_phase = 7'h00;
               next_state = ST_SAMPLE;
            end else begin
               next_phase = 7'(phase + 7'h01);
            end
         end
         ST_SAMPLE: begin
            if (phase == cfg.div) begin
               next_phase = 7'h00;
               next_rx_word[idx] = pin_f.din;
               if (cnt == 4'h0) begin
                  next_push = 1'b1;
                  next_state = ST_IDLE;
               end else begin
                  next_cnt = 4'(cnt - 4'h1);
                  next_idx = cfg.lsb_first ? 4'(idx + 4'h1) : 4'(idx - 4'h1);
                  next_state = ST_DRIVE;
               end
            end else begin
               next_phase = 7'(phase + 7'h01);
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         cfg <= '0;
         phase <= 7'h00;
         idx <= 4'h0;
         cnt <= 4'h0;
         rx_word <= 9'h000;
         push <= 1'b0;
      end else begin
         state <= next_state;
         cfg <= next_cfg;
         phase <= next_phase;
         idx <= next_idx;
         cnt <= next_cnt;
         rx_word <= next_rx_word;
         push <= next_push;
      end
   end

   // Received frames wait here until software reads them
   ccs_rx_buffer #(
      .WIDTH(9),
      .DEPTH(RX_DEPTH)
   ) u_rx_buffer (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(push),
      .in_ready(buf_in_ready),
      .in_data(rx_word),
      .out_valid(buf_out_valid),
      .out_ready(rx_pop),
      .out_data(buf_out_data)
   );

   // Serial values before the port latch and buffer
   assign serial_clk = active ? (state == ST_SAMPLE) : levels[CKO_BIT];
   assign serial_dout = (enables[SOE_BIT] && active) ? cfg.tx[idx] : levels[DOL_BIT];

   // Pin drive; enables are low while driving
   always_comb begin
      next_pin_out.clk = p3_latch[CLK_PIN_BIT] & serial_clk;
      next_pin_out.dout = p5_latch[OUT_PIN_BIT] & serial_dout;
      next_pin_out.din = p5_latch[IN_PIN_BIT];
      next_pin_oe_n.clk = p3_dir[CLK_PIN_BIT];
      next_pin_oe_n.dout = p5_dir[OUT_PIN_BIT];
      next_pin_oe_n.din = p5_dir[IN_PIN_BIT];
      // A level counts once the second and third stages agree
      next_pin_f = pin_f;
      if (sync2.clk == sync3.clk) begin
         next_pin_f.clk = sync3.clk;
      end
      if (sync2.dout == sync3.dout) begin
         next_pin_f.dout = sync3.dout;
      end
      if (sync2.din == sync3.din) begin
         next_pin_f.din = sync3.din;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= '0;
         pin_oe_n <= '1;
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pin_f <= '0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
         sync1 <= pin_in;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_f <= next_pin_f;
      end
   end

endmodule
`default_nettype wire

// [ccs_chk.sv]
// Assertion checker for the serial channel register port and pins
`timescale 1ns/10ps
`default_nettype none
module ccs_chk import ccs_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ccs_pins_s pin_oe_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Steps of one write: both halves taken, then a response left waiting
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   chk_wr_answer: assert property (s_both_taken |=> !s_axi_awready ##[0:2] s_axi_bvalid)
      else $error("write response missing");
   chk_resp_hold: assert property (s_resp_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
      && s_axi_awready && s_axi_wready)
      else $error("write channel not reopened");
   chk_b_cause: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
      else $error("response without a write");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && !s_axi_arready)
      else $error("read answer late");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped");
   chk_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
      && s_axi_arready)
      else $error("read channel not reopened");
   chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[5:2] > 4'hA |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_pins_released: assert property ($rose(aresetn) |-> pin_oe_n == 3'h7)
      else $error("pins driven after reset");
endmodule
bind ccs_channel ccs_chk u_chk (.*);
`default_nettype wire

// [ccs_peer.sv]
// Far-side serial device on the three-wire link
`timescale 1ns/10ps
`default_nettype none
module ccs_peer (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic arm,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [15:0] rx_bits,
   output logic [4:0] nbits
);
   logic [7:0] sh;
   // Reload per frame; released line flips so stale data never looks valid
   initial miso = 1'b0;
   always @(posedge arm) begin
      sh = tx_byte;
      nbits = 5'h0;
      rx_bits = 16'h0;
      miso = ~miso;
   end
   // Capture on the rising clock edge
   always @(posedge sclk) begin
      rx_bits = {rx_bits[14:0], mosi};
      nbits = nbits + 5'h1;
   end
   // Next bit on the falling edge, MSB first, released once the byte is out
   always @(negedge sclk) begin
      miso = (nbits < 5'h8) ? sh[7] : ~miso;
      sh = {sh[6:0], 1'b0};
   end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the clocked serial channel
`timescale 1ns/10ps
`default_nettype none
module tb_top import ccs_pkg::*;;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   ccs_pins_s pin_in, pin_out, pin_oe_n;
   logic clk_drv, arm, miso;
   logic [7:0] peer_tx;
   logic [15:0] peer_rx;
   logic [4:0] peer_n;
   int err_total, check_count, lo_cnt;
   ccs_channel uut (.*);
   ccs_peer peer (.sclk(pin_in.clk), .mosi(pin_in.dout), .arm(arm), .tx_byte(peer_tx),
      .miso(miso), .rx_bits(peer_rx), .nbits(peer_n));
   // Wire levels: a released pin shows the bench or the far side
   assign pin_in = {pin_oe_n.clk ? clk_drv : pin_out.clk,
      pin_oe_n.dout ? ~clk_drv : pin_out.dout, pin_oe_n.din ? miso : pin_out.din};
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // Count of aclk cycles with the serial clock pin low
   always @(posedge aclk) if (!pin_out.clk) lo_cnt <= lo_cnt + 1;
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tmo;
      err_total++;
      $display("Timeout at %0t", $time);
      wrap_up();
   endtask
   // Write: address and data offered together, each released when taken;
   // bready rises only once bvalid is seen, so the response must hold through a stall
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      repeat (50) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            return;
         end
         s_axi_bready <= s_axi_bvalid;
      end
      tmo();
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      repeat (50) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
         s_axi_rready <= s_axi_rvalid;
      end
      tmo();
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask
   // One frame; a data write lands mid-frame and must be ignored
   task automatic frame(input logic [7:0] t);
      peer_tx <= t;
      arm <= 1'b1;
      @(posedge aclk);
      arm <= 1'b0;
      lo_cnt = 0;
      wr(OFS_START, 32'h1);
      rd(OFS_STATUS);
      chk(d[6], 1'b1);
      wr(OFS_DATA, 32'h1FF);
      for (int i = 0; i < 60 && d[6]; i++) rd(OFS_STATUS);
      if (d[6]) tmo();
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 50'h0;
      s_axi_wstrb = 4'hF;
      {clk_drv, arm, peer_tx, err_total, check_count, lo_cnt} = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(pin_oe_n, 3'h7);
      rdc(OFS_MODE, 32'h3);
      rdc(OFS_DATA, 32'h0);
      rdc(OFS_LEVELS, 32'h101);
      rdc(OFS_ENABLES, 32'h0);
      rdc(OFS_P5_DIR, 32'hFF);
      rdc(6'h2C, 32'h0);
      chk(r, RESP_SLVERR);
      wr(6'h30, 32'h1);
      chk(r, RESP_SLVERR);
      // Refused length codes: 9-bit and the undefined one
      for (int c = 0; c < 2; c++) begin
         wr(OFS_MODE, c);
         wr(OFS_START, 32'h1);
         rdc(OFS_STATUS, 32'h2);
         wr(OFS_STATUS, 32'h2);
         rdc(OFS_STATUS, 32'h0);
      end
      wr(OFS_P3_DIR, 32'hFE);
      wr(OFS_P5_DIR, 32'hFD);
      wr(OFS_LEVELS, 32'h0);
      repeat (3) @(posedge aclk);
      chk(pin_oe_n, 3'h1);
      chk(pin_out, 3'h1);
      wr(OFS_LEVELS, 32'h101);
      repeat (3) @(posedge aclk);
      chk(pin_out, 3'h7);
      // Port latch low blocks the data level from the pin
      wr(OFS_P5_LATCH, 32'hFD);
      repeat (3) @(posedge aclk);
      chk(pin_out, 3'h5);
      wr(OFS_P5_LATCH, 32'hFF);
      // Clock pin as input: reads follow the pin level
      wr(OFS_P3_DIR, 32'hFF);
      for (int v = 0; v < 2; v++) begin
         clk_drv <= v[0];
         repeat (6) @(posedge aclk);
         rd(OFS_P3_LATCH);
         chk(d[0], v[0]);
      end
      wr(OFS_P3_DIR, 32'hFE);
      // 8-bit MSB first, divider 3 gives a 200 ns link clock
      wr(OFS_MODE, 32'h3);
      wr(OFS_DATA, 32'h6A6);
      wr(OFS_ENABLES, 32'h1);
      frame(8'h5C);
      chk(peer_rx[7:0], 8'hA6);
      chk(lo_cnt, 32);
      rdc(OFS_DATA, 32'h6A6);
      // 7-bit LSB first, output disabled so the data level bit shows; same 200 ns clock
      wr(OFS_MODE, 32'h82);
      wr(OFS_DATA, 32'h635);
      wr(OFS_ENABLES, 32'h0);
      frame(8'hC9);
      chk(peer_rx[6:0], 7'h7F);
      chk(peer_n, 5'h7);
      chk(lo_cnt, 28);
      // Buffer full: a further start is dropped
      wr(OFS_START, 32'h1);
      rdc(OFS_STATUS, 32'h1);
      rdc(OFS_RXDATA, 32'h5C);
      rdc(OFS_RXDATA, 32'h13);
      rdc(OFS_RXDATA, 32'h0);
      rdc(OFS_STATUS, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
